// ===== cms_core.sv
`timescale 1ns/1ps
`default_nettype none
module cms_core (
    // Clock and control
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Sequencer command
    input wire logic cmd_valid,
    input wire cms_pkg::cms_op_e cmd_op,
    input wire logic [cms_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [1:0] cmd_bit,
    input wire logic [cms_pkg::DIGIT_W-1:0] cmd_data,
    input wire logic cmd_flag,
    input wire logic [cms_pkg::PC_W-1:0] cmd_target,
    output logic cmd_ready,
    // Hardware events
    input wire logic halt_exit_input,
    input wire logic [cms_pkg::FLAG_W-1:0] irq_req_set,
    input wire logic capture_status_set,
    input wire logic capture_error_set,
    // Peripheral register window
    input wire logic [cms_pkg::DIGIT_W-1:0] sfr_rd_data,
    output logic sfr_rd,
    output logic sfr_wr,
    output logic [cms_pkg::ADDR_W-1:0] sfr_addr,
    output logic [cms_pkg::DIGIT_W-1:0] sfr_wr_data,
    // CPU state
    output logic [cms_pkg::DIGIT_W-1:0] acc,
    output logic [cms_pkg::DIGIT_W-1:0] breg,
    output logic overflow_flag,
    output logic branch_condition_flag,
    output logic [cms_pkg::PC_W-1:0] pc,
    output logic [cms_pkg::ADDR_W-1:0] sp,
    output logic [cms_pkg::ADDR_W-1:0] ind_addr,
    output logic [cms_pkg::DIGIT_W-1:0] port_bit_sel,
    output logic [cms_pkg::DIGIT_W-1:0] x_extension_reg,
    output logic [cms_pkg::DIGIT_W-1:0] y_extension_reg,
    output logic [cms_pkg::DIGIT_W-1:0] rd_data,
    output logic [cms_pkg::PAT_W-1:0] pattern_addr,
    output logic test_undef,
    // Flag bits
    output logic [cms_pkg::FLAG_W-1:0] irq_ctl,
    output logic global_irq_gate,
    output logic watchdog_run_flag,
    output logic capture_status_bit,
    output logic capture_error_bit
);
    import cms_pkg::*;

    typedef enum logic [1:0] {cms_idle, cms_push, cms_pop} cms_state_e;

    cms_state_e state_r, state_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic [SP_LO_W-1:0] sp_lo_r, sp_lo_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt;
    logic [DIGIT_W-1:0] acc_r, acc_nxt, breg_r, breg_nxt;
    logic ca_r, ca_nxt, st_r, st_nxt;
    logic [1:0] w_r, w_nxt;
    logic [DIGIT_W-1:0] x_r, x_nxt, y_r, y_nxt;
    logic [DIGIT_W-1:0] xe_r, xe_nxt, ye_r, ye_nxt;
    logic [FRAME_W-1:0] frame_r, frame_nxt;
    logic pop_irq_r, pop_irq_nxt;
    logic [FLAG_W-1:0] icb_r, icb_nxt, rfl_r, rfl_nxt;
    logic [DIGIT_W-1:0] rd_r, rd_nxt;
    logic [PAT_W-1:0] pat_r, pat_nxt;
    logic undef_r, undef_nxt;
    logic sfr_wr_r, sfr_wr_nxt;
    logic [ADDR_W-1:0] sfr_addr_r, sfr_addr_nxt;
    logic [DIGIT_W-1:0] sfr_wd_r, sfr_wd_nxt;

    function automatic logic in_rng(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] lo,
                                    input logic [ADDR_W-1:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    // Sparse RAM regions packed into one dense index space
    function automatic logic [IDX_W-1:0] ram_idx(
        input logic [ADDR_W-1:0] a);
        if (in_rng(a, SCR_LO, SCR_HI)) begin
            ram_idx = SCR_BASE + IDX_W'(a - SCR_LO);
        end else if (in_rng(a, DAT_LO, DAT_HI)) begin
            ram_idx = DAT_BASE + IDX_W'(a - DAT_LO);
        end else begin
            ram_idx = STK_BASE + IDX_W'(a - STK_LO);
        end
    endfunction

    cms_ram_if ram ();

    cms_ram u_ram (
        .ref_clk (ref_clk),
        .ce (ce),
        .ram (ram)
    );

    // Address and command decode
    wire accept = ce && cmd_valid && (state_r == cms_idle);
    wire is_ram = in_rng(cmd_addr, SCR_LO, SCR_HI) ||
        in_rng(cmd_addr, DAT_LO, DAT_HI) || in_rng(cmd_addr, STK_LO, STK_HI);
    wire is_icb = in_rng(cmd_addr, ICB_LO, ICB_HI);
    wire is_rfl = in_rng(cmd_addr, RFL_LO, RFL_HI);
    wire is_sfr = in_rng(cmd_addr, SFR1_LO, SFR1_HI) ||
        in_rng(cmd_addr, SFR2_LO, SFR2_HI);
    wire [3:0] fbit = {cmd_addr[1:0], cmd_bit};
    wire rfl_set_ok = (fbit == RFL_WDOG);
    wire rfl_clr_ok = fbit inside {RFL_REINIT, RFL_CAPS, RFL_CAPE};
    wire rfl_tst_ok = fbit inside {RFL_CAPS, RFL_CAPE};
    wire scr_op = cmd_op inside {load_acc_from_scratch, swap_acc_scratch};
    wire [IDX_W-1:0] scr_idx = SCR_BASE + IDX_W'(cmd_addr[3:0]);
    wire [PC_W-1:0] pc_inc = pc_r + PC_INC;
    wire [ADDR_W-1:0] sp_full = {SP_FIXED, sp_lo_r};

    // Push writes downward from sp, pop reads the frame above sp
    wire [SP_LO_W-1:0] stk_lo = (state_r == cms_push) ?
        sp_lo_r - SP_LO_W'(cnt_r) : sp_lo_r + SP_STEP - SP_LO_W'(cnt_r);
    wire [IDX_W-1:0] stk_idx = STK_BASE + IDX_W'(stk_lo);
    wire busy = (state_r != cms_idle);
    wire wr_mem = accept && (cmd_op == mem_write_op) && is_ram;
    wire wr_swap = accept && (cmd_op == swap_acc_scratch);

    assign ram.idx = busy ? stk_idx : (scr_op ? scr_idx : ram_idx(cmd_addr));
    assign ram.we = (ce && state_r == cms_push) || wr_mem || wr_swap;
    assign ram.wdata = (state_r == cms_push) ?
        frame_r[cnt_r * DIGIT_W +: DIGIT_W] :
        (wr_swap ? acc_r : cmd_data);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        sp_lo_nxt = sp_lo_r;
        pc_nxt = pc_r;
        acc_nxt = acc_r;
        breg_nxt = breg_r;
        ca_nxt = ca_r;
        st_nxt = st_r;
        w_nxt = w_r;
        x_nxt = x_r;
        y_nxt = y_r;
        xe_nxt = xe_r;
        ye_nxt = ye_r;
        frame_nxt = frame_r;
        pop_irq_nxt = pop_irq_r;
        icb_nxt = icb_r;
        rfl_nxt = rfl_r;
        rd_nxt = rd_r;
        pat_nxt = pat_r;
        undef_nxt = 1'b0;
        sfr_wr_nxt = 1'b0;
        sfr_addr_nxt = sfr_addr_r;
        sfr_wd_nxt = sfr_wd_r;
        if (accept) begin
            unique case (cmd_op)
                nop_op: begin
                end
                advance_op: pc_nxt = pc_inc;
                mem_read_op: begin
                    // Flag areas never answer a plain read
                    if (is_ram) begin
                        rd_nxt = ram.rdata;
                    end else if (is_sfr) begin
                        rd_nxt = sfr_rd_data;
                    end else begin
                        rd_nxt = '0;
                    end
                end
                mem_write_op: begin
                    if (is_sfr) begin
                        sfr_wr_nxt = 1'b1;
                        sfr_addr_nxt = cmd_addr;
                        sfr_wd_nxt = cmd_data;
                    end
                end
                bit_set_op: begin
                    if (is_icb) begin
                        icb_nxt[fbit] = 1'b1;
                    end else if (is_rfl && rfl_set_ok) begin
                        rfl_nxt[fbit] = 1'b1;
                    end
                end
                bit_clear_op: begin
                    if (is_icb) begin
                        icb_nxt[fbit] = 1'b0;
                    end else if (is_rfl && rfl_clr_ok) begin
                        rfl_nxt[fbit] = 1'b0;
                        if (fbit == RFL_REINIT) begin
                            sp_lo_nxt = SP_LO_RST;
                        end
                    end
                end
                bit_test_op: begin
                    if (is_icb) begin
                        st_nxt = icb_r[fbit];
                    end else if (is_rfl && rfl_tst_ok) begin
                        st_nxt = rfl_r[fbit];
                    end else begin
                        undef_nxt = 1'b1;
                    end
                end
                load_acc_from_scratch: acc_nxt = ram.rdata;
                swap_acc_scratch: acc_nxt = ram.rdata;
                arith_op: begin
                    acc_nxt = cmd_data;
                    ca_nxt = cmd_flag;
                    st_nxt = cmd_flag;
                end
                status_op: st_nxt = cmd_flag;
                carry_set_op: ca_nxt = 1'b1;
                carry_clear_op: ca_nxt = 1'b0;
                rotate_left_op: {ca_nxt, acc_nxt} = {acc_r, ca_r};
                rotate_right_op: {acc_nxt, ca_nxt} = {ca_r, acc_r};
                load_b_op: breg_nxt = cmd_data;
                load_ptr_op: begin
                    case (cms_ptr_e'(cmd_addr[2:0]))
                        ptr_w: w_nxt = cmd_data[1:0];
                        ptr_x: x_nxt = cmd_data;
                        ptr_y: y_nxt = cmd_data;
                        ptr_xext: xe_nxt = cmd_data;
                        ptr_yext: ye_nxt = cmd_data;
                        default: begin
                        end
                    endcase
                end
                long_jump_op: pc_nxt = cmd_target;
                near_jump_op: begin
                    pc_nxt = st_r ?
                        {pc_r[PC_W-1:NEAR_W], cmd_target[NEAR_W-1:0]} :
                        pc_inc;
                    st_nxt = 1'b1;
                end
                far_jump_op: begin
                    pc_nxt = st_r ? cmd_target : pc_inc;
                    st_nxt = 1'b1;
                end
                call_op, short_call_op: begin
                    // Frame is {st, ca, pc}; top digit pushed last
                    pc_nxt = pc_inc;
                    if (st_r) begin
                        frame_nxt = {st_r, ca_r, pc_inc};
                        state_nxt = cms_push;
                        cnt_nxt = '0;
                        pc_nxt = (cmd_op == short_call_op) ?
                            (cmd_target & ZP_MASK) : cmd_target;
                    end
                    st_nxt = 1'b1;
                end
                irq_enter_op: begin
                    frame_nxt = {st_r, ca_r, pc_r};
                    state_nxt = cms_push;
                    cnt_nxt = '0;
                    pc_nxt = cmd_target & VEC_MASK;
                end
                plain_return_op, irq_return_op: begin
                    pop_irq_nxt = (cmd_op == irq_return_op);
                    state_nxt = cms_pop;
                    cnt_nxt = '0;
                end
                pattern_op: pat_nxt = cmd_target[PAT_W-1:0];
                // Codes past the last command are ignored
                default: begin
                end
            endcase
        end
        if (state_r == cms_push) begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == FRM_LAST) begin
                state_nxt = cms_idle;
                sp_lo_nxt = sp_lo_r - SP_STEP;
            end
        end
        if (state_r == cms_pop) begin
            cnt_nxt = cnt_r + 2'h1;
            frame_nxt[cnt_r * DIGIT_W +: DIGIT_W] = ram.rdata;
            if (cnt_r == FRM_LAST) begin
                state_nxt = cms_idle;
                sp_lo_nxt = sp_lo_r + SP_STEP;
                pc_nxt = {ram.rdata[PCHI_W-1:0],
                          frame_r[FRAME_W-DIGIT_W-1:0]};
                if (pop_irq_r) begin
                    st_nxt = ram.rdata[FRM_ST];
                    ca_nxt = ram.rdata[FRM_CA];
                end
            end
        end
        // Hardware sets come last so they beat a same-cycle clear
        icb_nxt = icb_nxt | (irq_req_set & IRQ_REQ_MASK);
        if (capture_status_set) begin
            rfl_nxt[RFL_CAPS] = 1'b1;
        end
        if (capture_error_set) begin
            rfl_nxt[RFL_CAPE] = 1'b1;
        end
        if (halt_exit_input) begin
            rfl_nxt[RFL_WDOG] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= cms_idle;
            cnt_r <= '0;
            sp_lo_r <= SP_LO_RST;
            pc_r <= PC_RST;
            acc_r <= '0;
            breg_r <= '0;
            ca_r <= 1'b0;
            st_r <= 1'b1;
            w_r <= '0;
            x_r <= '0;
            y_r <= '0;
            xe_r <= '0;
            ye_r <= '0;
            frame_r <= '0;
            pop_irq_r <= 1'b0;
            icb_r <= ICB_RST;
            rfl_r <= RFL_RST;
            rd_r <= '0;
            pat_r <= '0;
            undef_r <= 1'b0;
            sfr_wr_r <= 1'b0;
            sfr_addr_r <= '0;
            sfr_wd_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            sp_lo_r <= sp_lo_nxt;
            pc_r <= pc_nxt;
            acc_r <= acc_nxt;
            breg_r <= breg_nxt;
            ca_r <= ca_nxt;
            st_r <= st_nxt;
            w_r <= w_nxt;
            x_r <= x_nxt;
            y_r <= y_nxt;
            xe_r <= xe_nxt;
            ye_r <= ye_nxt;
            frame_r <= frame_nxt;
            pop_irq_r <= pop_irq_nxt;
            icb_r <= icb_nxt;
            rfl_r <= rfl_nxt;
            rd_r <= rd_nxt;
            pat_r <= pat_nxt;
            undef_r <= undef_nxt;
            sfr_wr_r <= sfr_wr_nxt;
            sfr_addr_r <= sfr_addr_nxt;
            sfr_wd_r <= sfr_wd_nxt;
        end
    end

    assign cmd_ready = !busy;
    assign sfr_rd = accept && (cmd_op == mem_read_op) && is_sfr;
    assign sfr_wr = sfr_wr_r;
    assign sfr_addr = sfr_addr_r;
    assign sfr_wr_data = sfr_wd_r;
    assign acc = acc_r;
    assign breg = breg_r;
    assign overflow_flag = ca_r;
    assign branch_condition_flag = st_r;
    assign pc = pc_r;
    assign sp = sp_full;
    assign ind_addr = {w_r, x_r, y_r};
    assign port_bit_sel = y_r;
    assign x_extension_reg = xe_r;
    assign y_extension_reg = ye_r;
    assign rd_data = rd_r;
    assign pattern_addr = pat_r;
    assign test_undef = undef_r;
    assign irq_ctl = icb_r;
    assign global_irq_gate = icb_r[IRQ_GATE];
    assign watchdog_run_flag = rfl_r[RFL_WDOG];
    assign capture_status_bit = rfl_r[RFL_CAPS];
    assign capture_error_bit = rfl_r[RFL_CAPE];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_reset_values: assert property (
        disable iff (1'b0) rst |=> pc_r == PC_RST && st_r &&
        sp_full == SP_RST && icb_r == ICB_RST && !rfl_r[RFL_WDOG])
        else $error("reset values wrong");
    a_push_sp_step: assert property (
        (ce && state_r == cms_push && cnt_r == FRM_LAST) |=>
        sp_lo_r == $past(sp_lo_r) - SP_STEP && state_r == cms_idle)
        else $error("push did not lower sp by four");
    a_pop_sp_step: assert property (
        (ce && state_r == cms_pop && cnt_r == FRM_LAST) |=>
        sp_lo_r == $past(sp_lo_r) + SP_STEP)
        else $error("pop did not raise sp by four");
    a_frame_top_digit: assert property (
        (ce && state_r == cms_push && cnt_r == FRM_LAST) |->
        ram.we && ram.wdata[FRM_ST] == frame_r[FRAME_W-1] &&
        ram.idx == STK_BASE + IDX_W'(sp_lo_r - SP_LO_W'(FRM_LAST)))
        else $error("top frame digit misplaced");
    a_wdog_no_clear: assert property (
        (accept && cmd_op == bit_clear_op && is_rfl &&
         fbit == RFL_WDOG && !halt_exit_input) |=>
        $stable(rfl_r[RFL_WDOG]))
        else $error("watchdog flag cleared by software");
    a_halt_clears_wdog: assert property (
        (ce && halt_exit_input) |=> !watchdog_run_flag)
        else $error("halt exit left watchdog flag set");
    a_reinit_reload_sp: assert property (
        (accept && cmd_op == bit_clear_op && is_rfl &&
         fbit == RFL_REINIT) |=> sp == SP_RST)
        else $error("reinit clear did not reload sp");
    a_jump_sets_st: assert property (
        (accept && cmd_op inside {near_jump_op, far_jump_op,
         call_op, short_call_op}) |=> branch_condition_flag)
        else $error("jump fetch left branch flag low");
    a_short_call_zp: assert property (
        (accept && cmd_op == short_call_op && st_r) |=>
        (pc_r & ~ZP_MASK) == '0 ##1 state_r == cms_push)
        else $error("short call left zero page");
    a_irq_vector: assert property (
        (accept && cmd_op == irq_enter_op) |=>
        (pc_r & ~VEC_MASK) == '0 && state_r == cms_push)
        else $error("interrupt entry outside vector area");
    a_plain_ret_flags: assert property (
        (ce && state_r == cms_pop && cnt_r == FRM_LAST && !pop_irq_r)
        |=> st_r == $past(st_r) && ca_r == $past(ca_r))
        else $error("plain return changed flags");
    a_test_inhibit: assert property (
        (accept && cmd_op == bit_test_op && is_rfl && !rfl_tst_ok)
        |=> test_undef && $stable(st_r))
        else $error("inhibited test not flagged");
endmodule
`default_nettype wire

// ===== cms_pkg.sv
// Overview of operation
// - Reset and interrupts start at vector entries
// - Short call targets only 0x0000 to 0x003F
// - Pattern lookup reaches ROM 0x0000 to 0x0FFF
// - Data memory is 512 four-bit locations
// - Interrupt control bits: bit operations only
// - Peripheral registers: no bit operations
// - Register flags: bit operations only
// - Watchdog flag set only, reinit clear only
// - Reset or halt exit clears watchdog flag
// - Testing inhibited bit leaves branch flag undefined
// - Sixteen scratch registers for load and swap
// - Data storage from 0x090 through 0x23F
// - Sixteen-level stack saves PC and flags
// - Plain return restores PC, interrupt return all
// - Accumulator and second register, four bits
// - Pointer registers form indirect RAM address
// - Overflow flag set by arithmetic, carry, rotates
// - Branch flag latches results, set by near and far jumps and calls
// - Program counter is fourteen bits
// - Stack pointer steps by four, top fixed
// - Clearing reinit bit reloads stack pointer
// - Reset values of PC, flags and masks
package cms_pkg;
    localparam int DIGIT_W = 4;
    localparam int ADDR_W = 10;
    localparam int IDX_W = 9;
    localparam int RAM_DEPTH = 512;
    localparam int PC_W = 14;
    localparam int PAT_W = 12;
    localparam int FLAG_W = 16;
    localparam int FRAME_W = 16;
    localparam int SP_LO_W = 6;
    localparam int NEAR_W = 6;
    localparam int PCHI_W = 2;
    localparam int FRM_ST = 3;
    localparam int FRM_CA = 2;
    localparam logic [ADDR_W-1:0] ICB_LO = 10'h000;
    localparam logic [ADDR_W-1:0] ICB_HI = 10'h003;
    localparam logic [ADDR_W-1:0] SFR1_LO = 10'h004;
    localparam logic [ADDR_W-1:0] SFR1_HI = 10'h018;
    localparam logic [ADDR_W-1:0] RFL_LO = 10'h020;
    localparam logic [ADDR_W-1:0] RFL_HI = 10'h023;
    localparam logic [ADDR_W-1:0] SFR2_LO = 10'h024;
    localparam logic [ADDR_W-1:0] SFR2_HI = 10'h034;
    localparam logic [ADDR_W-1:0] SCR_LO = 10'h040;
    localparam logic [ADDR_W-1:0] SCR_HI = 10'h04F;
    localparam logic [ADDR_W-1:0] DAT_LO = 10'h090;
    localparam logic [ADDR_W-1:0] DAT_HI = 10'h23F;
    localparam logic [ADDR_W-1:0] STK_LO = 10'h3C0;
    localparam logic [ADDR_W-1:0] STK_HI = 10'h3FF;
    localparam logic [IDX_W-1:0] SCR_BASE = 9'h000;
    localparam logic [IDX_W-1:0] DAT_BASE = 9'h010;
    localparam logic [IDX_W-1:0] STK_BASE = 9'h1C0;
    localparam logic [PC_W-1:0] PC_RST = 14'h0000;
    localparam logic [PC_W-1:0] PC_INC = 14'h0001;
    localparam logic [PC_W-1:0] VEC_MASK = 14'h000F;
    localparam logic [PC_W-1:0] ZP_MASK = 14'h003F;
    localparam logic [ADDR_W-1:0] SP_RST = 10'h3FF;
    localparam logic [3:0] SP_FIXED = 4'hF;
    localparam logic [SP_LO_W-1:0] SP_LO_RST = 6'h3F;
    localparam logic [SP_LO_W-1:0] SP_STEP = 6'h04;
    localparam logic [1:0] FRM_LAST = 2'h3;
    localparam logic [FLAG_W-1:0] ICB_RST = 16'hAAAA;
    localparam logic [FLAG_W-1:0] IRQ_REQ_MASK = 16'h5554;
    localparam logic [FLAG_W-1:0] RFL_RST = 16'h0000;
    localparam logic [3:0] IRQ_GATE = 4'h0;
    localparam logic [3:0] RFL_WDOG = 4'h0;
    localparam logic [3:0] RFL_REINIT = 4'h1;
    localparam logic [3:0] RFL_CAPS = 4'h2;
    localparam logic [3:0] RFL_CAPE = 4'h3;
    typedef enum logic [4:0] {
        nop_op, advance_op, mem_read_op, mem_write_op,
        bit_set_op, bit_clear_op, bit_test_op,
        load_acc_from_scratch, swap_acc_scratch,
        arith_op, status_op, carry_set_op, carry_clear_op,
        rotate_left_op, rotate_right_op, load_b_op, load_ptr_op,
        long_jump_op, near_jump_op, far_jump_op, call_op,
        short_call_op, irq_enter_op, plain_return_op,
        irq_return_op, pattern_op
    } cms_op_e;
    typedef enum logic [2:0] {
        ptr_w, ptr_x, ptr_y, ptr_xext, ptr_yext
    } cms_ptr_e;
endpackage

// ===== cms_ram_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cms_ram_if;
    import cms_pkg::*;
    logic we;
    logic [IDX_W-1:0] idx;
    logic [DIGIT_W-1:0] wdata;
    logic [DIGIT_W-1:0] rdata;
    modport ctl (output we, output idx, output wdata, input rdata);
    modport mem (input we, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== cms_ram.sv
`timescale 1ns/1ps
`default_nettype none
module cms_ram (
    // Clock
    input wire logic ref_clk,
    input wire logic ce,
    // Storage port
    cms_ram_if.mem ram
);
    import cms_pkg::*;
    // Plain data, so no reset
    logic [DIGIT_W-1:0] mem_r [RAM_DEPTH];
    always_ff @(posedge ref_clk) begin
        if (ce && ram.we) begin
            mem_r[ram.idx] <= ram.wdata;
        end
    end
    assign ram.rdata = mem_r[ram.idx];
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cms_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, cmd_valid = 1'b0;
    cms_op_e cmd_op = nop_op;
    logic [ADDR_W-1:0] cmd_addr = 10'h000;
    logic [1:0] cmd_bit = 2'h0;
    logic [DIGIT_W-1:0] cmd_data = 4'h0;
    logic cmd_flag = 1'b0, halt_exit_input = 1'b0, cmd_ready, test_undef;
    logic [PC_W-1:0] cmd_target = 14'h0000, pc;
    logic [FLAG_W-1:0] irq_ctl;
    logic [ADDR_W-1:0] sp, ind;
    logic [DIGIT_W-1:0] rd_data, acc;
    logic [PAT_W-1:0] pat;
    logic ovf, stf, wdog;
    int n_errors = 0, compares = 0;
    always #5 ref_clk = ~ref_clk;
    cms_core u_dut (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_bit(cmd_bit), .cmd_data(cmd_data), .cmd_flag(cmd_flag),
        .cmd_target(cmd_target), .cmd_ready(cmd_ready),
        .halt_exit_input(halt_exit_input), .irq_req_set(16'h0000),
        .capture_status_set(1'b0), .capture_error_set(1'b0),
        .sfr_rd_data(4'h0), .sfr_rd(), .sfr_wr(), .sfr_addr(),
        .sfr_wr_data(), .acc(acc), .breg(), .overflow_flag(ovf),
        .branch_condition_flag(stf), .pc(pc), .sp(sp), .ind_addr(ind),
        .port_bit_sel(), .x_extension_reg(), .y_extension_reg(),
        .rd_data(rd_data), .pattern_addr(pat), .test_undef(test_undef),
        .irq_ctl(irq_ctl), .global_irq_gate(), .watchdog_run_flag(wdog),
        .capture_status_bit(), .capture_error_bit());
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Stack operations hold ready low for four cycles; allow margin
    task automatic cmd(input cms_op_e op, input logic [9:0] a,
                       input logic [1:0] b, input logic [3:0] d,
                       input logic f, input logic [13:0] t);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_bit <= b;
        cmd_data <= d;
        cmd_flag <= f;
        cmd_target <= t;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 20) begin
            n_errors++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk(16'(pc), 16'h0000);
        chk(16'(stf), 16'h0001);
        chk(irq_ctl, 16'hAAAA);
        chk(16'(sp), 16'h03FF);
        cmd(bit_set_op, 10'h020, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(wdog), 16'h0001);
        cmd(bit_clear_op, 10'h020, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(wdog), 16'h0001);
        cmd(bit_test_op, 10'h020, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(test_undef), 16'h0001);
        @(posedge ref_clk);
        halt_exit_input <= 1'b1;
        @(posedge ref_clk);
        halt_exit_input <= 1'b0;
        #1;
        chk(16'(wdog), 16'h0000);
        cmd(mem_write_op, 10'h23F, 2'h0, 4'hA, 1'b0, 14'h0);
        cmd(mem_write_op, 10'h000, 2'h0, 4'h5, 1'b0, 14'h0);
        cmd(mem_read_op, 10'h23F, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(rd_data), 16'h000A);
        cmd(mem_read_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(rd_data), 16'h0000);
        chk(irq_ctl, 16'hAAAA);
        // Call from 0 pushes 1 with branch flag 1 and overflow 0
        cmd(call_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0123);
        chk(16'(pc), 16'h0123);
        chk(16'(sp), 16'h03FB);
        cmd(arith_op, 10'h000, 2'h0, 4'h3, 1'b0, 14'h0);
        cmd(carry_set_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(ovf), 16'h0001);
        cmd(irq_enter_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0004);
        chk(16'(pc), 16'h0004);
        chk(16'(sp), 16'h03F7);
        cmd(carry_clear_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0);
        cmd(arith_op, 10'h000, 2'h0, 4'h3, 1'b1, 14'h0);
        chk({14'h0, stf, ovf}, 16'h0003);
        cmd(irq_return_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0);
        chk({stf, ovf, pc}, 16'h4123);
        cmd(plain_return_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0);
        chk({stf, ovf, pc}, 16'h4001);
        chk(16'(sp), 16'h03FF);
        // Branch flag is 0 here: call is skipped but sets the flag
        cmd(call_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0010);
        chk({1'b0, stf, pc}, 16'h4002);
        cmd(call_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0010);
        chk(16'(sp), 16'h03FB);
        cmd(bit_clear_op, 10'h020, 2'h1, 4'h0, 1'b0, 14'h0);
        chk(16'(sp), 16'h03FF);
        cmd(short_call_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0FFF);
        chk(16'(pc), 16'h003F);
        cmd(mem_write_op, 10'h045, 2'h0, 4'h9, 1'b0, 14'h0);
        cmd(arith_op, 10'h000, 2'h0, 4'h6, 1'b0, 14'h0);
        cmd(swap_acc_scratch, 10'h045, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(acc), 16'h0009);
        cmd(load_acc_from_scratch, 10'h045, 2'h0, 4'h0, 1'b0,
            14'h0);
        chk(16'(acc), 16'h0006);
        cmd(pattern_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h3ABC);
        chk(16'(pat), 16'h0ABC);
        cmd(load_ptr_op, 10'h000, 2'h0, 4'h2, 1'b0, 14'h0);
        cmd(load_ptr_op, 10'h001, 2'h0, 4'h5, 1'b0, 14'h0);
        cmd(load_ptr_op, 10'h002, 2'h0, 4'hC, 1'b0, 14'h0);
        chk(16'(ind), 16'h025C);
        // Clock enable low: offered command must not be taken
        @(posedge ref_clk);
        ce <= 1'b0;
        cmd(carry_set_op, 10'h000, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(ovf), 16'h0000);
        @(posedge ref_clk);
        ce <= 1'b1;
        // Reset in mid-run clears the watchdog flag again
        cmd(bit_set_op, 10'h020, 2'h0, 4'h0, 1'b0, 14'h0);
        chk(16'(wdog), 16'h0001);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk(16'(wdog), 16'h0000);
        chk({1'b0, stf, pc}, 16'h4000);
        chk(16'(sp), 16'h03FF);
        give_verdict();
    end
endmodule
`default_nettype wire
